// ==== bec_core.sv ====
// backlight enable, standby/active mode decision and register port
// assumes scl, sda_in, pwm_in and hardware_enable_pin are synchronous to sys_clk
module bec_core (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        hardware_enable_pin,
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        pwm_in,
  input  wire logic [2:0]  sink_grounded,
  output logic             shutdown,
  output logic             bl_standby,
  output logic             boost_en,
  output logic [2:0]       sink_en,
  output logic [10:0]      led_level,
  output logic             linear_map,
  output bec_pkg::bec_freq_t boost_freq
);
  logic             clr;
  logic [7:0]       dim_r, ramp_r, blo_r, bhi_r, afa_r, afb_r, ben_r, fbd_r;
  logic [11:0]      rdy_cnt_r;
  logic             ready;
  logic             scl_p_r, sda_p_r;
  logic             start_c, stop_c, rise_c, fall_c;
  bec_pkg::bec_bus_t  st_r;
  bec_pkg::bec_kind_t kind_r;
  logic [7:0]       sh_r, ptr_r, rd_c;
  logic [3:0]       cnt_r;
  logic             rw_r;
  logic             wr_c;
  logic [10:0]      bright_c, win_r, duty_r, target_c;
  logic [11:0]      hi_r;
  logic [21:0]      prod_c;
  logic             pwm_act_c, active_c, act_p_r;
  logic [2:0]       mask_r, sinks_c;
  logic [7:0]       step_r;

  assign clr = rst | ~hardware_enable_pin;

  always_ff @(posedge sys_clk) begin
    if (clr) rdy_cnt_r <= '0;
    else if (rdy_cnt_r != bec_pkg::READY_CYC) rdy_cnt_r <= rdy_cnt_r + 12'h001;
  end
  assign ready = (rdy_cnt_r == bec_pkg::READY_CYC);

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      scl_p_r <= scl;
      sda_p_r <= sda_in;
    end
  end
  assign start_c = ready & scl & scl_p_r & sda_p_r & ~sda_in;
  assign stop_c  = ready & scl & scl_p_r & ~sda_p_r & sda_in;
  assign rise_c  = scl & ~scl_p_r;
  assign fall_c  = ~scl & scl_p_r;

  always_comb begin
    case (ptr_r)
      bec_pkg::OFF_DIMMING:     rd_c = dim_r;
      bec_pkg::OFF_BOOST_RAMP:  rd_c = ramp_r;
      bec_pkg::OFF_BRIGHT_LO:   rd_c = blo_r;
      bec_pkg::OFF_BRIGHT_HI:   rd_c = bhi_r;
      bec_pkg::OFF_AUTO_FREQ_A: rd_c = afa_r;
      bec_pkg::OFF_AUTO_FREQ_B: rd_c = afb_r;
      bec_pkg::OFF_BL_ENABLE:   rd_c = ben_r;
      bec_pkg::OFF_FB_DISABLE:  rd_c = fbd_r;
      default:                  rd_c = 8'h00;
    endcase
  end

  assign wr_c = (st_r == bec_pkg::BEC_RX) & fall_c & (cnt_r == 4'h8)
              & (kind_r == bec_pkg::BEC_K_DATA);

  // two-wire slave, write: addr reg data..., read: addr data...
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      st_r    <= bec_pkg::BEC_IDLE;
      kind_r  <= bec_pkg::BEC_K_ADDR;
      sh_r    <= 8'h00;
      ptr_r   <= 8'h00;
      cnt_r   <= 4'h0;
      rw_r    <= 1'b0;
      sda_oe  <= 1'b0;
    end else if (start_c) begin
      st_r   <= bec_pkg::BEC_RX;
      kind_r <= bec_pkg::BEC_K_ADDR;
      cnt_r  <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_c) begin
      st_r   <= bec_pkg::BEC_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (st_r)
        bec_pkg::BEC_RX: begin
          if (rise_c && cnt_r != 4'h8) begin
            sh_r  <= {sh_r[6:0], sda_in};
            cnt_r <= cnt_r + 4'h1;
          end else if (fall_c && cnt_r == 4'h8) begin
            st_r   <= bec_pkg::BEC_ACK;
            sda_oe <= 1'b1;
            case (kind_r)
              bec_pkg::BEC_K_ADDR: begin
                rw_r   <= sh_r[0];
                kind_r <= bec_pkg::BEC_K_REG;
                if (sh_r[7:1] != bec_pkg::DEV_ADDR) begin
                  st_r   <= bec_pkg::BEC_IDLE;
                  sda_oe <= 1'b0;
                end
              end
              bec_pkg::BEC_K_REG: begin
                ptr_r  <= sh_r;
                kind_r <= bec_pkg::BEC_K_DATA;
              end
              default: ptr_r <= ptr_r + 8'h01;
            endcase
          end
        end
        bec_pkg::BEC_ACK: begin
          if (fall_c) begin
            cnt_r <= 4'h0;
            if (rw_r && kind_r == bec_pkg::BEC_K_REG) begin
              st_r   <= bec_pkg::BEC_TX;
              sh_r   <= rd_c;
              sda_oe <= ~rd_c[7];
              ptr_r  <= ptr_r + 8'h01;
            end else begin
              st_r   <= bec_pkg::BEC_RX;
              sda_oe <= 1'b0;
            end
          end
        end
        bec_pkg::BEC_TX: begin
          if (fall_c) begin
            if (cnt_r == 4'h7) begin
              st_r   <= bec_pkg::BEC_TXACK;
              sda_oe <= 1'b0;
            end else begin
              cnt_r  <= cnt_r + 4'h1;
              sh_r   <= {sh_r[6:0], 1'b0};
              sda_oe <= ~sh_r[6];
            end
          end
        end
        bec_pkg::BEC_TXACK: begin
          // nack from host ends the read
          if (rise_c && sda_in) st_r <= bec_pkg::BEC_IDLE;
          else if (fall_c) begin
            st_r   <= bec_pkg::BEC_TX;
            cnt_r  <= 4'h0;
            sh_r   <= rd_c;
            sda_oe <= ~rd_c[7];
            ptr_r  <= ptr_r + 8'h01;
          end
        end
        default: st_r <= bec_pkg::BEC_IDLE;
      endcase
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge sys_clk) begin
    sda_out <= 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      dim_r  <= bec_pkg::RST_DIMMING;
      ramp_r <= bec_pkg::RST_BOOST_RAMP;
      blo_r  <= bec_pkg::RST_BRIGHT_LO;
      bhi_r  <= bec_pkg::RST_BRIGHT_HI;
      afa_r  <= bec_pkg::RST_AUTO_FREQ;
      afb_r  <= bec_pkg::RST_AUTO_FREQ;
      ben_r  <= bec_pkg::RST_BL_ENABLE;
      fbd_r  <= bec_pkg::RST_FB_DISABLE;
    end else if (wr_c) begin
      case (ptr_r)
        bec_pkg::OFF_DIMMING:     dim_r  <= sh_r;
        bec_pkg::OFF_BOOST_RAMP:  ramp_r <= sh_r;
        bec_pkg::OFF_BRIGHT_LO:   blo_r  <= sh_r;
        bec_pkg::OFF_BRIGHT_HI:   bhi_r  <= sh_r;
        bec_pkg::OFF_AUTO_FREQ_A: afa_r  <= sh_r;
        bec_pkg::OFF_AUTO_FREQ_B: afb_r  <= sh_r;
        bec_pkg::OFF_BL_ENABLE:   ben_r  <= sh_r;
        bec_pkg::OFF_FB_DISABLE:  fbd_r  <= sh_r;
        default: ;
      endcase
    end
  end

  assign bright_c  = {bhi_r, blo_r[2:0]};
  assign pwm_act_c = pwm_in ^ dim_r[bec_pkg::BIT_PWM_POL];

  // duty over a fixed 2048-cycle window; below ~10 kHz the reading wobbles
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      win_r  <= '0;
      hi_r   <= '0;
      duty_r <= '0;
    end else begin
      win_r <= win_r + 11'h001;
      if (win_r == 11'h7FF) begin
        duty_r <= hi_r[11] ? 11'h7FF : hi_r[10:0];
        hi_r   <= {11'h000, pwm_act_c};
      end else begin
        hi_r <= hi_r + {11'h000, pwm_act_c};
      end
    end
  end

  assign prod_c = bright_c * duty_r;
  assign target_c = dim_r[bec_pkg::BIT_PWM_EN] ? prod_c[21:11] : bright_c;
  assign sinks_c = ben_r[2:0] & ~mask_r;
  assign active_c = ben_r[bec_pkg::BIT_BL_ON] && bright_c != 11'h000 && sinks_c != 3'h0
                 && !(dim_r[bec_pkg::BIT_PWM_EN] && duty_r == 11'h000);

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      act_p_r <= 1'b0;
      mask_r  <= 3'h0;
    end else begin
      act_p_r <= active_c;
      if (active_c && !act_p_r) mask_r <= mask_r | (ben_r[2:0] & sink_grounded);
    end
  end

  // ramp toward target, immediate zero on clr
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      step_r    <= 8'h00;
      led_level <= 11'h000;
    end else begin
      step_r <= (step_r == bec_pkg::RAMP_STEP_CYC - 8'h01) ? 8'h00 : step_r + 8'h01;
      if (step_r == 8'h00) begin
        if (!active_c && led_level != 11'h000) led_level <= led_level - 11'h001;
        else if (active_c && led_level < target_c) led_level <= led_level + 11'h001;
        else if (active_c && led_level > target_c) led_level <= led_level - 11'h001;
      end
    end
  end

  // boost and sinks follow the level
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      boost_en   <= 1'b0;
      sink_en    <= 3'h0;
      bl_standby <= 1'b0;
      linear_map <= 1'b0;
      shutdown   <= 1'b1;
    end else begin
      boost_en   <= (led_level != 11'h000) && sinks_c != 3'h0
                 && fbd_r[5:3] != bec_pkg::FB_ALL_OFF;
      sink_en    <= (led_level != 11'h000) ? sinks_c : 3'h0;
      bl_standby <= (led_level == 11'h000) && !active_c;
      linear_map <= dim_r[bec_pkg::BIT_LIN_MAP];
      shutdown   <= 1'b0;
    end
  end

  // frequency pick, auto threshold a drops it only to 500K like bit 7, auto threshold b drops it further to 250K
  always_ff @(posedge sys_clk) begin
    if (clr) boost_freq <= bec_pkg::BEC_F1000K;
    else if (afb_r != 8'h00 && bhi_r < afb_r) boost_freq <= bec_pkg::BEC_F250K;
    else if (ramp_r[bec_pkg::BIT_FREQ_LOW] || (afa_r != 8'h00 && bhi_r < afa_r))
      boost_freq <= bec_pkg::BEC_F500K;
    else boost_freq <= bec_pkg::BEC_F1000K;
  end
endmodule // bec_core

// ==== bec_pkg.sv ====
// constants for the backlight enable and mode control block
// assumes a 20 MHz system clock and an i2c-style two-wire register port
// Operation
// - With the hardware enable pin low the device is shut down, every register is at default and bus traffic is ignored.
// - With the hardware enable pin high the device is in standby and its two-wire interface answers the host from READY_CYC cycles (150 us) after the pin rises.
// - Pulling the hardware enable pin low stops the LED current at once with no ramp and disables the bus.
// - Turning the backlight off by bus command ramps the current down and leaves the bus alive.
// - The boost switches at one of three frequencies chosen by bit 7 of boost_ramp_config and the auto-frequency registers auto_frequency_a and auto_frequency_b.
// - Each of the three sinks is enabled by its own bit in backlight_enable_ctrl[2:0].
// - At backlight startup any sink tied to ground is detected and its channel disabled.
// - With PWM dimming on and nonzero duty the bus brightness is scaled by the measured duty.
// - The backlight stays in standby if the on bit is 0, the code is 0x000, no sink is enabled, or PWM is on with zero duty.
// - In backlight standby boost and sinks are off while register writes are still accepted.
// - When active the enabled sinks run with boost on, boost stays off if feedback_disable_ctrl[5:3] is 111, and dimming_config[3] picks linear mapping.
// - The 11-bit brightness code is brightness_high_bits[7:0] as high bits and brightness_low_bits[2:0] as low bits.
// - Bit 0 of dimming_config selects bus-only brightness (0) or bus code times PWM duty (1).
package bec_pkg;
  // bus device address, arbitrary value
  localparam logic [6:0]  DEV_ADDR        = 7'h2A;
  localparam logic [7:0]  OFF_DIMMING     = 8'h02;
  localparam logic [7:0]  OFF_BOOST_RAMP  = 8'h03;
  localparam logic [7:0]  OFF_BRIGHT_LO   = 8'h04;
  localparam logic [7:0]  OFF_BRIGHT_HI   = 8'h05;
  localparam logic [7:0]  OFF_AUTO_FREQ_A = 8'h06;
  localparam logic [7:0]  OFF_AUTO_FREQ_B = 8'h07;
  localparam logic [7:0]  OFF_BL_ENABLE   = 8'h08;
  localparam logic [7:0]  OFF_FB_DISABLE  = 8'h10;
  localparam logic [7:0]  RST_DIMMING     = 8'h00;
  localparam logic [7:0]  RST_BOOST_RAMP  = 8'h00;
  localparam logic [7:0]  RST_BRIGHT_LO   = 8'h07;
  localparam logic [7:0]  RST_BRIGHT_HI   = 8'h00;
  localparam logic [7:0]  RST_AUTO_FREQ   = 8'h00;
  localparam logic [7:0]  RST_BL_ENABLE   = 8'h00;
  localparam logic [7:0]  RST_FB_DISABLE  = 8'h00;
  localparam int          BIT_PWM_EN      = 0;
  localparam int          BIT_PWM_POL     = 2;
  localparam int          BIT_LIN_MAP     = 3;
  localparam int          BIT_FREQ_LOW    = 7;
  localparam int          BIT_BL_ON       = 4;
  localparam logic [2:0]  FB_ALL_OFF      = 3'h7;
  localparam int          CLK_HZ          = 20_000_000;
  localparam int          T_READY_US      = 150;
  localparam logic [11:0] READY_CYC       =
    12'((64'd150 * 64'd20_000_000 + 64'd999_999) / 64'd1_000_000);
  localparam int          T_RAMP_STEP_NS  = 1000;
  localparam logic [7:0]  RAMP_STEP_CYC   =
    8'((64'd1000 * 64'd20_000_000) / 64'd1_000_000_000);
  typedef enum logic [1:0] {BEC_F1000K, BEC_F500K, BEC_F250K} bec_freq_t;
  typedef enum logic [2:0] {BEC_IDLE, BEC_RX, BEC_ACK, BEC_TX, BEC_TXACK} bec_bus_t;
  typedef enum logic [1:0] {BEC_K_ADDR, BEC_K_REG, BEC_K_DATA} bec_kind_t;
endpackage

// ==== bec_core_assertions.sv ====
// port checker for bec_core, bound at the foot of this file
// assumes one sys_clk domain and rst synchronous active high
module bec_core_chk (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        hardware_enable_pin,
  input wire logic        scl,
  input wire logic        sda_oe,
  input wire logic [2:0]  sink_grounded,
  input wire logic        shutdown,
  input wire logic        bl_standby,
  input wire logic        boost_en,
  input wire logic [2:0]  sink_en,
  input wire logic [10:0] led_level
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // ramp steps are 20 cycles apart, 8 is a safe lower bound
  sequence s_hold;
    $stable(led_level)[*8];
  endsequence
  sequence s_step;
    led_level == $past(led_level) + 11'h1 || led_level == $past(led_level) - 11'h1;
  endsequence
  property p_off;
    !hardware_enable_pin |=> shutdown && led_level == 11'h0 && !sda_oe;
  endproperty
  property p_wake;
    $fell(shutdown) |-> bl_standby && !sda_oe;
  endproperty
  property p_quiet;
    shutdown |-> !boost_en && sink_en == 3'h0 && led_level == 11'h0;
  endproperty
  property p_stby;
    bl_standby |-> !boost_en && sink_en == 3'h0;
  endproperty
  property p_sink;
    boost_en |-> sink_en != 3'h0;
  endproperty
  property p_gnd;
    (sink_en & sink_grounded) == 3'h0;
  endproperty
  // the drop to zero on enable low is no ramp step, p_off covers it
  property p_ramp;
    disable iff (rst || !hardware_enable_pin)
    $changed(led_level) && !shutdown |-> s_step ##1 s_hold;
  endproperty
  property p_lvl;
    led_level != 11'h0 |=> !bl_standby;
  endproperty
  property p_ack;
    $rose(sda_oe) |-> !scl;
  endproperty
  a_off: assert property (p_off) else $error("enable low not honoured");
  a_wake: assert property (p_wake) else $error("wake state wrong");
  a_quiet: assert property (p_quiet) else $error("shutdown not quiet");
  a_stby: assert property (p_stby) else $error("standby drives sinks");
  a_sink: assert property (p_sink) else $error("boost without sink");
  a_gnd: assert property (p_gnd) else $error("grounded sink enabled");
  a_ramp: assert property (p_ramp) else $error("level jumped");
  a_lvl: assert property (p_lvl) else $error("standby with level");
  a_ack: assert property (p_ack) else $error("sda driven in clock high");
endmodule // bec_core_chk

bind bec_core bec_core_chk chk_u (.sys_clk, .rst, .hardware_enable_pin, .scl, .sda_oe,
  .sink_grounded, .shutdown, .bl_standby, .boost_en, .sink_en, .led_level);

// ==== bec_host.sv ====
// two-wire host and pwm source facing bec_core
// assumes sda is open drain with pull-up; drives on falling sys_clk
module bec_host (
  input  wire logic sys_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe,
  output logic      pwm
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'h1;
    sda_oe = 1'h0;
    pwm = 1'h0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // phases of 4 cycles, above the 2 cycle minimum
  task automatic bit_io(input logic d, output logic q);
    wt(1);
    sda_oe = !d;
    wt(3);
    scl = 1'h1;
    wt(3);
    q = sda;
    wt(1);
    scl = 1'h0;
  endtask
  task automatic start();
    wt(3);
    sda_oe = 1'h1;
    wt(3);
    scl = 1'h0;
  endtask
  task automatic stop();
    wt(1);
    sda_oe = 1'h1;
    wt(3);
    scl = 1'h1;
    wt(3);
    sda_oe = 1'h0;
  endtask
  // host releases the ninth bit: ack on write, nack ends a read
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      q[i] = b;
    end
    bit_io(1'h1, b);
  endtask
  task automatic write_reg(input logic [7:0] off, input logic [7:0] v);
    logic [7:0] q;
    start();
    xfer({bec_pkg::DEV_ADDR, 1'h0}, q);
    xfer(off, q);
    xfer(v, q);
    stop();
  endtask
  // pointer set by an offset-only write, so no register is touched
  task automatic read_reg(input logic [7:0] off, output logic [7:0] v);
    logic [7:0] q;
    start();
    xfer({bec_pkg::DEV_ADDR, 1'h0}, q);
    xfer(off, q);
    stop();
    start();
    xfer({bec_pkg::DEV_ADDR, 1'h1}, q);
    xfer(8'hFF, v);
    stop();
  endtask
  task automatic set_pwm(input logic v);
    wt(1);
    pwm = v;
  endtask
endmodule // bec_host

// ==== bec_core_tb.sv ====
// self-checking bench for bec_core, bus traffic through bec_host
// assumes bec_pkg, bec_core, bec_host and the checker compiled first
module bec_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic               sys_clk;
  logic               rst;
  logic               hardware_enable_pin;
  logic [2:0]         sink_grounded;
  logic               scl;
  logic               h_oe;
  logic               pwm_in;
  logic               sda_oe;
  logic               shutdown;
  logic               bl_standby;
  logic               boost_en;
  logic [2:0]         sink_en;
  logic [10:0]        led_level;
  logic               linear_map;
  bec_pkg::bec_freq_t boost_freq;
  logic [7:0]         v;
  int                 bad_count = 0;
  int                 checks_done = 0;
  wire                sda_in = !(h_oe || sda_oe);
  bec_core dut_u (.sys_clk, .rst, .hardware_enable_pin, .scl, .sda_in, .sda_out(), .sda_oe,
    .pwm_in, .sink_grounded, .shutdown, .bl_standby, .boost_en, .sink_en, .led_level,
    .linear_map, .boost_freq);
  bec_host host_u (.sys_clk, .sda(sda_in), .scl, .sda_oe(h_oe), .pwm(pwm_in));
  initial begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] off, input logic [7:0] e);
    host_u.read_reg(off, v);
    chk(11'(v), 11'(e));
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // run is near 25k cycles, the 60k-cycle limit allows over twice that
  initial begin
    #3_000_000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    rst = 1'h1;
    hardware_enable_pin = 1'h1;
    sink_grounded = 3'h0;
    repeat (20) @(negedge sys_clk);
    rst = 1'h0;
    host_u.write_reg(bec_pkg::OFF_BRIGHT_HI, 8'h55);
    repeat (3000) @(negedge sys_clk);
    rd(bec_pkg::OFF_BRIGHT_HI, 8'h00);
    host_u.write_reg(8'h09, 8'hFF);
    for (int a = 2; a <= 16; a++) begin
      rd(8'(a), (a == 4) ? bec_pkg::RST_BRIGHT_LO : 8'h00);
    end
    $display("test defaults done");
    sink_grounded = 3'h2;
    // level before sinks and the on bit, which go in one write
    host_u.write_reg(bec_pkg::OFF_BRIGHT_HI, 8'h01);
    host_u.write_reg(bec_pkg::OFF_BL_ENABLE, 8'h13);
    repeat (400) @(negedge sys_clk);
    chk(led_level, 11'h00F);
    chk(11'(sink_en), 11'h001);
    chk(11'(boost_en), 11'h001);
    chk(11'(bl_standby), 11'h000);
    host_u.write_reg(bec_pkg::OFF_FB_DISABLE, 8'h38);
    host_u.write_reg(bec_pkg::OFF_DIMMING, 8'h08);
    chk(11'(boost_en), 11'h000);
    chk(11'(sink_en), 11'h001);
    chk(11'(linear_map), 11'h001);
    $display("test active done");
    host_u.write_reg(bec_pkg::OFF_BOOST_RAMP, 8'h80);
    chk(11'(boost_freq), 11'(bec_pkg::BEC_F500K));
    host_u.write_reg(bec_pkg::OFF_AUTO_FREQ_B, 8'h02);
    chk(11'(boost_freq), 11'(bec_pkg::BEC_F250K));
    host_u.write_reg(bec_pkg::OFF_AUTO_FREQ_B, 8'h00);
    host_u.write_reg(bec_pkg::OFF_BOOST_RAMP, 8'h00);
    chk(11'(boost_freq), 11'(bec_pkg::BEC_F1000K));
    $display("test frequency done");
    host_u.write_reg(bec_pkg::OFF_DIMMING, 8'h09);
    repeat (5000) @(negedge sys_clk);
    chk(led_level, 11'h000);
    chk(11'(bl_standby), 11'h001);
    rd(bec_pkg::OFF_BL_ENABLE, 8'h13);
    host_u.set_pwm(1'h1);
    repeat (5000) @(negedge sys_clk);
    chk(led_level, 11'h00E);
    $display("test pwm done");
    hardware_enable_pin = 1'h0;
    @(negedge sys_clk);
    chk(led_level, 11'h000);
    chk(11'(shutdown), 11'h001);
    hardware_enable_pin = 1'h1;
    repeat (3010) @(negedge sys_clk);
    rd(bec_pkg::OFF_BL_ENABLE, 8'h00);
    $display("test shutdown done");
    report_and_stop();
  end
endmodule // bec_core_tb
